//--- rtl/escvc_top.v
// Exception state, vector table offset and reset/grouping register block.
// How it works
// - Writing 1 to deferred set bit makes it pending; read shows pending state.
// - Only a written 1 to that set bit makes the deferred exception pending.
// - Writing 1 to deferred clear bit removes pending; 0 does nothing.
// - Writing 1 to tick set bit makes tick pending; read shows tick pending.
// - Writing 1 to tick clear bit removes tick pending; reads zero.
// - Debug-reserved bit reads zero outside debug state.
// - Interrupt pending flag reads 1 when any interrupt, not fault, pends.
// - Highest pending field shows top pending enabled exception, else 0.
// - Highest pending honours base-priority and fault masks, ignores primary mask.
// - Return-to-base reads 0 while preempted active exceptions remain.
// - Active field is 0 in thread mode, else status exception number bits 8:0.
// - Offset field holds table offset bits 29 to 7; bits 6 to 0 zero.
// - Offset bit 29 picks code region (0) or SRAM region (1).
// - Reset/grouping writes ignored unless key field carries 0x05fa.
// - Key field reads back as 0xfa05.
// - Endianness bit loaded once, on the third clock after reset ends, from the big-endian configuration input.
// - Writing 1 to reset request pulses the reset request output; reads 0.
// - Debug reset bits read 0; software writes 0 to them.
// - Grouping field sets the group/subpriority split, 3 through 7.
// - Preemption compares group priority fields only.
// - Control/state register holds set and clear bits beside status fields.
// - Reset/grouping register resets to 0xfa050000.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "escvc_map.vh"

module escvc_top (
  // Clock and reset.
  input wire mclk,
  input wire rst_b,
  // Register port.
  input wire [`ESCVC_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire reg_priv,
  output reg [31:0] reg_rdata,
  // Strap sampled through the synchroniser after reset is released.
  input wire big_endian_config_input,
  // Status from the core and arbiter.
  input wire debug_state,
  input wire any_irq_pending,
  input wire [8:0] arb_pending_number,
  input wire [3:0] arb_pending_group,
  input wire arb_pending_is_fault,
  input wire [3:0] base_priority_mask,
  input wire fault_mask_a,
  input wire [8:0] program_status_exception_field,
  input wire [7:0] active_count,
  input wire [3:0] cur_priority,
  input wire [3:0] new_priority,
  // Outputs to the system.
  output wire deferred_service_exception,
  output wire system_tick_exception,
  output reg system_reset_request,
  output wire [31:0] vector_table_offset,
  output wire [2:0] priority_grouping_field,
  output wire data_endianness_bit,
  output wire preempt_allowed
);

  // Two stages keep a metastable first stage away from every reader of the strap.
  localparam SYNC_STAGES = 2;

  // Register state and next values.
  reg ds_pend_q;
  reg ds_pend_d;
  reg st_pend_q;
  reg st_pend_d;
  reg [31:0] vto_q;
  reg [31:0] vto_d;
  reg [2:0] grp_q;
  reg [2:0] grp_d;
  reg [2:0] grp_eff_q;
  reg [2:0] grp_eff_d;
  reg endian_q;
  reg endian_d;
  reg [1:0] cap_cnt_q;
  reg [1:0] cap_cnt_d;
  reg sysrst_d;
  reg [31:0] rdata_d;

  // Strap synchroniser chain.
  reg [SYNC_STAGES-1:0] strap_sync_q;
  wire strap_sync;

  // Status path.
  reg [3:0] pend_grp_part;
  reg [3:0] base_grp_part;
  reg base_blocks;
  reg fault_blocks;
  reg [8:0] highest_pending_number;

  // Read words.
  reg [31:0] ics_word;
  reg [31:0] vto_word;
  reg [31:0] rpg_word;

  // Write qualifiers.
  wire wr_ok;
  wire wr_ics;
  wire wr_vto;
  wire key_ok;
  wire wr_rpg;
  wire ds_set_req;
  wire ds_clr_req;
  wire st_set_req;
  wire st_clr_req;

  // True when the address selects the given register.
  function addr_is;
    input [`ESCVC_ADDR_W-1:0] addr;
    input [`ESCVC_ADDR_W-1:0] offset;
    begin
      addr_is = (addr == offset);
    end
  endfunction

  // Keeps only the group part of a four-bit priority for the given split.
  function [3:0] group_of;
    input [3:0] pri;
    input [2:0] grp;
    begin
      case (grp)
        3'h4: group_of = {pri[3:1], 1'b0};
        3'h5: group_of = {pri[3:2], 2'b00};
        3'h6: group_of = {pri[3], 3'b000};
        3'h7: group_of = 4'h0;
        default: group_of = pri;
      endcase
    end
  endfunction

  // Values below the first implemented split behave as that split.
  function [2:0] clamp_grp;
    input [2:0] grp;
    begin
      if (grp < `ESCVC_GRP_MIN) begin
        clamp_grp = `ESCVC_GRP_MIN;
      end else begin
        clamp_grp = grp;
      end
    end
  endfunction

  // Writes need privilege; the reset/grouping register needs the key as well.
  assign wr_ok = reg_wr & reg_priv;
  assign wr_ics = wr_ok & addr_is(reg_addr, `ESCVC_OFF_ICS);
  assign wr_vto = wr_ok & addr_is(reg_addr, `ESCVC_OFF_VTO);
  assign key_ok = (reg_wdata[31:16] == `ESCVC_KEY_WRITE);
  assign wr_rpg = wr_ok & addr_is(reg_addr, `ESCVC_OFF_RPG) & key_ok;
  assign ds_set_req = wr_ics & reg_wdata[`ESCVC_BIT_DS_SET];
  assign ds_clr_req = wr_ics & reg_wdata[`ESCVC_BIT_DS_CLR];
  assign st_set_req = wr_ics & reg_wdata[`ESCVC_BIT_ST_SET];
  assign st_clr_req = wr_ics & reg_wdata[`ESCVC_BIT_ST_CLR];

  // Outputs.
  assign deferred_service_exception = ds_pend_q;
  assign system_tick_exception = st_pend_q;
  assign vector_table_offset = vto_q;
  assign priority_grouping_field = grp_eff_q;
  assign data_endianness_bit = endian_q;
  assign strap_sync = strap_sync_q[SYNC_STAGES-1];

  // Preemption looks at group priority alone, so subpriority never decides it.
  assign preempt_allowed =
    group_of(new_priority, grp_eff_q) < group_of(cur_priority, grp_eff_q);

  // The fault mask hides every non-fault exception; a nonzero base priority hides non-fault ones whose group priority is not above it.
  always @* begin
    pend_grp_part = group_of(arb_pending_group, grp_eff_q);
    base_grp_part = group_of(base_priority_mask, grp_eff_q);
    base_blocks = (base_priority_mask != 4'h0) && (pend_grp_part >= base_grp_part);
    fault_blocks = fault_mask_a;
    highest_pending_number = arb_pending_number;
    if (!arb_pending_is_fault && (fault_blocks || base_blocks)) begin
      highest_pending_number = 9'h000;
    end
  end

  // Strap synchroniser; only the last stage is read by logic.
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_STAGES; gi = gi + 1) begin : g_strap_sync
      if (gi == 0) begin : g_first
        always @(posedge mclk or negedge rst_b) begin
          if (!rst_b) begin
            strap_sync_q[0] <= 1'b0;
          end else begin
            strap_sync_q[0] <= big_endian_config_input;
          end
        end
      end else begin : g_next
        always @(posedge mclk or negedge rst_b) begin
          if (!rst_b) begin
            strap_sync_q[gi] <= 1'b0;
          end else begin
            strap_sync_q[gi] <= strap_sync_q[gi-1];
          end
        end
      end
    end
  endgenerate

  // The strap is taken once, only after it has passed the whole synchroniser.
  // Taking it earlier would load the reset value of the chain instead of the pin.
  always @* begin
    cap_cnt_d = cap_cnt_q;
    endian_d = endian_q;
    if (cap_cnt_q != 2'h3) begin
      cap_cnt_d = cap_cnt_q + 2'h1;
    end
    if (cap_cnt_q == `ESCVC_STRAP_CAP) begin
      endian_d = strap_sync;
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cap_cnt_q <= 2'h0;
      endian_q <= 1'b0;
    end else begin
      cap_cnt_q <= cap_cnt_d;
      endian_q <= endian_d;
    end
  end

  // Set wins over clear when software writes both.
  always @* begin
    ds_pend_d = ds_pend_q;
    if (ds_set_req) begin
      ds_pend_d = 1'b1;
    end else if (ds_clr_req) begin
      ds_pend_d = 1'b0;
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ds_pend_q <= 1'b0;
    end else begin
      ds_pend_q <= ds_pend_d;
    end
  end

  // Tick pending follows the same set-over-clear order.
  always @* begin
    st_pend_d = st_pend_q;
    if (st_set_req) begin
      st_pend_d = 1'b1;
    end else if (st_clr_req) begin
      st_pend_d = 1'b0;
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_pend_q <= 1'b0;
    end else begin
      st_pend_q <= st_pend_d;
    end
  end

  // Offset bits outside the table field are forced to zero.
  always @* begin
    vto_d = vto_q;
    if (wr_vto) begin
      vto_d = reg_wdata & `ESCVC_VTO_MASK;
    end
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      vto_q <= `ESCVC_VTO_RST;
    end else begin
      vto_q <= vto_d;
    end
  end

  // The raw field reads back as written; the system sees the clamped split.
  always @* begin
    grp_d = grp_q;
    if (wr_rpg) begin
      grp_d = reg_wdata[`ESCVC_GRP_MSB:`ESCVC_GRP_LSB];
    end
    grp_eff_d = clamp_grp(grp_d);
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      grp_q <= 3'h0;
      grp_eff_q <= `ESCVC_GRP_MIN;
    end else begin
      grp_q <= grp_d;
      grp_eff_q <= grp_eff_d;
    end
  end

  // The request is a one-cycle pulse; nothing holds it.
  always @* begin
    sysrst_d = wr_rpg & reg_wdata[`ESCVC_BIT_SYSRST];
  end

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      system_reset_request <= 1'b0;
    end else begin
      system_reset_request <= sysrst_d;
    end
  end

  // Clear-pending bits and the debug-reserved bit always read zero.
  always @* begin
    ics_word = 32'h00000000;
    ics_word[`ESCVC_BIT_DS_SET] = ds_pend_q;
    ics_word[`ESCVC_BIT_DS_CLR] = 1'b0;
    ics_word[`ESCVC_BIT_ST_SET] = st_pend_q;
    ics_word[`ESCVC_BIT_ST_CLR] = 1'b0;
    ics_word[`ESCVC_BIT_DBG] = debug_state & 1'b0;
    ics_word[`ESCVC_BIT_ISRP] = any_irq_pending;
    ics_word[`ESCVC_HPN_LSB +: 9] = highest_pending_number;
    ics_word[`ESCVC_BIT_RTB] = (active_count <= 8'h01);
    ics_word[8:0] = program_status_exception_field;
  end

  always @* begin
    vto_word = vto_q;
  end

  // The key field reads as the status value, never as the written key.
  always @* begin
    rpg_word = 32'h00000000;
    rpg_word[31:16] = `ESCVC_KEY_STAT;
    rpg_word[`ESCVC_BIT_ENDIAN] = endian_q;
    rpg_word[`ESCVC_GRP_MSB:`ESCVC_GRP_LSB] = grp_q;
    rpg_word[`ESCVC_BIT_SYSRST] = 1'b0;
    rpg_word[1:0] = 2'b00;
  end

  // Unmapped addresses read zero.
  always @* begin
    case (reg_addr)
      `ESCVC_OFF_ICS: begin
        rdata_d = ics_word;
      end
      `ESCVC_OFF_VTO: begin
        rdata_d = vto_word;
      end
      `ESCVC_OFF_RPG: begin
        rdata_d = rpg_word;
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // escvc_top

//--- shared/escvc_map.vh
// Register offsets, field positions, reset values and keys for the exception state block.
`ifndef ESCVC_MAP_VH
`define ESCVC_MAP_VH
`define ESCVC_ADDR_W 4
`define ESCVC_OFF_ICS 4'h4
`define ESCVC_OFF_VTO 4'h8
`define ESCVC_OFF_RPG 4'hc
`define ESCVC_BIT_DS_SET 28
`define ESCVC_BIT_DS_CLR 27
`define ESCVC_BIT_ST_SET 26
`define ESCVC_BIT_ST_CLR 25
`define ESCVC_BIT_DBG 23
`define ESCVC_BIT_ISRP 22
`define ESCVC_BIT_RTB 11
`define ESCVC_VTO_MASK 32'h3fffff80
`define ESCVC_VTO_RST 32'h00000000
`define ESCVC_KEY_WRITE 16'h05fa
`define ESCVC_KEY_STAT 16'hfa05
`define ESCVC_RPG_RST 32'hfa050000
`define ESCVC_BIT_ENDIAN 15
`define ESCVC_BIT_SYSRST 2
`define ESCVC_GRP_MIN 3'h3
`define ESCVC_GRP_LSB 8
`define ESCVC_GRP_MSB 10
`define ESCVC_HPN_LSB 12
`define ESCVC_STRAP_CAP 2'h2
`endif

//--- tb/escvc_asserts.sv
// Port checker for the exception state and grouping register block.
`timescale 1ns/10ps
module escvc_asserts (
  input wire mclk, input wire rst_b, input wire reg_wr, input wire reg_priv,
  input wire [3:0] reg_addr, input wire [31:0] reg_wdata,
  input wire deferred_service_exception, input wire system_tick_exception,
  input wire system_reset_request, input wire [31:0] vector_table_offset,
  input wire [2:0] priority_grouping_field, input wire preempt_allowed,
  input wire [3:0] cur_priority, input wire [3:0] new_priority
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire ics_w = reg_wr && reg_priv && reg_addr == 4'h4;
  wire key_w = reg_wr && reg_priv && reg_addr == 4'hc && reg_wdata[31:16] == 16'h05fa;
  sequence req_s; key_w && reg_wdata[2]; endsequence
  sequence pulse_s; system_reset_request ##1 !system_reset_request; endsequence
  a_reset_pulse: assert property (req_s |=> pulse_s) else $error("bad reset pulse");
  a_reset_keyed: assert property (system_reset_request |-> $past(key_w && reg_wdata[2]))
    else $error("unkeyed reset request");
  a_ds_only_set: assert property ($rose(deferred_service_exception) |-> $past(ics_w && reg_wdata[28]))
    else $error("deferred pending without set");
  a_ds_clear: assert property (ics_w && reg_wdata[27] && !reg_wdata[28] |=> !deferred_service_exception)
    else $error("deferred clear ignored");
  a_tick_set: assert property (ics_w && reg_wdata[26] |=> system_tick_exception)
    else $error("tick set ignored");
  a_tick_clear: assert property (ics_w && reg_wdata[25] && !reg_wdata[26] |=> !system_tick_exception)
    else $error("tick clear ignored");
  a_offset_zero: assert property ((vector_table_offset & 32'hc000007f) == 32'h0)
    else $error("offset low or top bits set");
  a_group_floor: assert property (priority_grouping_field >= 3'h3) else $error("grouping below 3");
  a_group_none: assert property (priority_grouping_field == 3'h7 |-> !preempt_allowed)
    else $error("preempt with no group bits");
  a_group_flat: assert property (priority_grouping_field == 3'h3 |-> preempt_allowed == (new_priority < cur_priority))
    else $error("flat grouping compare wrong");
  a_unpriv_hold: assert property (reg_wr && !reg_priv |=> $stable(vector_table_offset))
    else $error("unprivileged write took effect");
endmodule // escvc_asserts

//--- tb/escvc_top_bench.sv
// Self-checking bench for the exception state and grouping register block.
`timescale 1ns/10ps
module escvc_top_bench;
  reg mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, reg_priv = 1;
  reg big_endian_config_input = 1, debug_state = 0, any_irq_pending = 1;
  reg arb_pending_is_fault = 0, fault_mask_a = 0;
  reg [3:0] reg_addr = 4'h0, arb_pending_group = 4'h5, base_priority_mask = 4'h0;
  reg [3:0] cur_priority = 4'h5, new_priority = 4'h4;
  reg [31:0] reg_wdata = 32'h0;
  reg [8:0] arb_pending_number = 9'h1f, program_status_exception_field = 9'h0e;
  reg [7:0] active_count = 8'h1;
  wire [31:0] reg_rdata, vector_table_offset;
  wire [2:0] priority_grouping_field;
  wire deferred_service_exception, system_tick_exception, system_reset_request;
  wire data_endianness_bit, preempt_allowed;
  integer failures = 0, tests_run = 0;
  escvc_top dut (.*);
  always #10 mclk = ~mclk;
  task chk(input [31:0] s, input [31:0] e); begin
    tests_run = tests_run + 1;
    if (s !== e) begin
      failures = failures + 1;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  end endtask
  task wr(input [3:0] a, input [31:0] d); begin
    @(posedge mclk); reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge mclk); reg_wr <= 0; #1;
  end endtask
  task rd(input [3:0] a, input [31:0] e); begin
    @(posedge mclk); reg_rd <= 1; reg_addr <= a;
    @(posedge mclk); reg_rd <= 0; #1 chk(reg_rdata, e);
  end endtask
  task t_status; begin
    wr(4'h4, 32'h10000000); chk(deferred_service_exception, 1);
    rd(4'h4, 32'h1041f80e);
    chk(reg_rdata[20:12] - 9'h010, 32'h0000000f);
    fault_mask_a <= 1; active_count <= 8'h2; any_irq_pending <= 0;
    rd(4'h4, 32'h1000000e);
    fault_mask_a <= 0; base_priority_mask <= 4'h5;
    rd(4'h4, 32'h1000000e);
    wr(4'h4, 32'h08000000); chk(deferred_service_exception, 0);
    wr(4'h4, 32'h04000000); chk(system_tick_exception, 1);
    wr(4'h4, 32'h02000000); chk(system_tick_exception, 0);
  end endtask
  task t_priv; begin
    reg_priv <= 0; wr(4'h4, 32'h10000000); wr(4'h8, 32'h00000080); reg_priv <= 1;
    chk(deferred_service_exception, 0);
    chk(vector_table_offset, 0);
  end endtask
  task t_offset; begin
    wr(4'h8, 32'hffffff80); rd(4'h8, 32'h3fffff80);
    chk(vector_table_offset[29], 1);
    wr(4'h8, 32'h00000100); chk(vector_table_offset, 32'h00000100);
  end endtask
  task t_group; begin
    wr(4'hc, 32'h00000500); chk(priority_grouping_field, 3);
    wr(4'hc, 32'h05fa0500); chk(priority_grouping_field, 5);
    rd(4'hc, 32'hfa058500);
    wr(4'hc, 32'h05fa0700); chk(preempt_allowed, 0);
    wr(4'hc, 32'h05fa0400); chk(preempt_allowed, 0);
    wr(4'hc, 32'h05fa0100); chk({priority_grouping_field, preempt_allowed}, 7);
  end endtask
  task t_sysreset; begin
    wr(4'hc, 32'h05fa0004); chk(system_reset_request, 1);
    @(posedge mclk); #1 chk(system_reset_request, 0);
    rd(4'h0, 32'h0);
  end endtask
  task print_verdict; begin
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  end endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1;
    repeat (3) @(posedge mclk);
    rd(4'hc, 32'hfa058000); chk(data_endianness_bit, 1);
    t_status; t_priv; t_offset; t_group; t_sysreset;
    print_verdict;
  end
  initial begin
    #20000;
    failures = failures + 1;
    print_verdict;
  end
endmodule // escvc_top_bench
bind escvc_top escvc_asserts u_chk (.*);
